// ---- cmpc_ctrl.sv ----
// comparator control: tasks, events, links, interrupt enables, config
`timescale 1ns/1ps
module cmpc_ctrl (
   input  wire logic                        clock_i,
   input  wire logic                        rst_n_i,
   input  wire logic                        awvalid_i,
   output logic                             awready_o,
   input  wire logic [cmpc_pkg::ADDR_W-1:0] awaddr_i,
   input  wire logic                        wvalid_i,
   output logic                             wready_o,
   input  wire logic [31:0]                 wdata_i,
   input  wire logic [3:0]                  wstrb_i,
   output logic                             bvalid_o,
   input  wire logic                        bready_i,
   output logic [1:0]                       bresp_o,
   input  wire logic                        arvalid_i,
   output logic                             arready_o,
   input  wire logic [cmpc_pkg::ADDR_W-1:0] araddr_i,
   output logic                             rvalid_o,
   input  wire logic                        rready_i,
   output logic [31:0]                      rdata_o,
   output logic [1:0]                       rresp_o,
   input  wire logic                        cmp_above_i,
   input  wire logic                        core_ready_i,
   output logic                             core_run_o,
   output logic                             ladder_upper_o,
   output logic [5:0]                       ladder_level_o,
   output logic [2:0]                       ref_source_o,
   output logic [2:0]                       ref_pin_o,
   output logic                             ref_pin_en_o,
   output logic [2:0]                       positive_input_o,
   output logic [1:0]                       speed_power_o,
   output logic                             diff_mode_o,
   output logic                             diff_hyst_o,
   output logic                             irq_o
);
   import cmpc_pkg::*;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] m;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      return (old & ~m) | (d & m);
   endfunction

   function automatic logic known(input logic [ADDR_W-1:0] a);
      case (a)
         OFS_START, OFS_STOP, OFS_SAMPLE, OFS_EV_RDY, OFS_EV_DN, OFS_EV_UP,
         OFS_EV_CRS, OFS_LINKS, OFS_IRQ, OFS_IRQ_SET, OFS_IRQ_CLR, OFS_RESULT,
         OFS_ENABLE, OFS_PSEL, OFS_REFSRC, OFS_EXTREF, OFS_TH, OFS_MODE,
         OFS_HYST: known = 1'b1;
         default:  known = 1'b0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // register bus
   logic              wr_en;
   logic [ADDR_W-1:0] wr_addr;
   logic [31:0]       wr_data;
   logic [3:0]        wr_strb;
   logic              rd_en;
   logic [31:0]       rd_data;

   cmpc_axil u_bus (
      .clock_i   (clock_i),
      .rst_n_i   (rst_n_i),
      .awvalid_i (awvalid_i),
      .awready_o (awready_o),
      .awaddr_i  (awaddr_i),
      .wvalid_i  (wvalid_i),
      .wready_o  (wready_o),
      .wdata_i   (wdata_i),
      .wstrb_i   (wstrb_i),
      .bvalid_o  (bvalid_o),
      .bready_i  (bready_i),
      .bresp_o   (bresp_o),
      .arvalid_i (arvalid_i),
      .arready_o (arready_o),
      .rvalid_o  (rvalid_o),
      .rready_i  (rready_i),
      .rdata_o   (rdata_o),
      .rresp_o   (rresp_o),
      .wr_en_o   (wr_en),
      .wr_addr_o (wr_addr),
      .wr_data_o (wr_data),
      .wr_strb_o (wr_strb),
      .wr_ok_i   (known(wr_addr)),
      .rd_en_o   (rd_en),
      .rd_data_i (rd_data),
      .rd_ok_i   (known(araddr_i))
   );

   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic [3:0]  events;
   logic [4:0]  links;
   logic [3:0]  irq_en;
   logic        result;
   logic [1:0]  block_on;
   logic [2:0]  pos_pick;
   logic [2:0]  ref_src;
   logic [2:0]  ext_ref;
   logic [5:0]  th_up;
   logic [5:0]  th_dn;
   logic [1:0]  speed_power;
   logic        main_diff;
   logic        hyst_on;
   cmpc_run_e   state;
   cmpc_run_e   next_state;

   wire [31:0] wr_m     = merge(32'h00000000, wr_data, wr_strb);
   wire        hit_st   = wr_en && wr_addr == OFS_START && wr_m[0];
   wire        hit_sp   = wr_en && wr_addr == OFS_STOP && wr_m[0];
   wire        hit_smp  = wr_en && wr_addr == OFS_SAMPLE && wr_m[0];
   wire        enabled  = block_on == EN_ON;
   wire        live     = state == CMPC_LIVE;
   wire        rdy_ev   = state == CMPC_WARM && core_ready_i;
   wire        up_ev;
   wire        dn_ev;
   wire        crs_ev   = up_ev | dn_ev;

   cmpc_cross u_cross (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .live_i  (live),
      .above_i (cmp_above_i),
      .up_o    (up_ev),
      .down_o  (dn_ev)
   );

   wire [3:0] ev_pulse = {crs_ev, up_ev, dn_ev, rdy_ev};
   // link-driven stops act in the same cycle as their event
   wire stop_go  = hit_sp | (rdy_ev & links[LK_RDY_STP]) | (dn_ev & links[LK_DN_STP])
                 | (up_ev & links[LK_UP_STP]) | (crs_ev & links[LK_CRS_STP]);
   wire start_go = hit_st & enabled & ~stop_go;
   wire sample_go = hit_smp | (rdy_ev & links[LK_RDY_SMP]);

   ////////////////////////////////////////////////////////////////////////////
   // run state: idle, waiting for the core, live
   always_comb begin
      next_state = state;
      case (state)
         CMPC_IDLE: begin
            if (start_go) next_state = CMPC_WARM;
         end
         CMPC_WARM: begin
            if (stop_go) next_state = CMPC_IDLE;
            else if (core_ready_i) next_state = CMPC_LIVE;
         end
         CMPC_LIVE: begin
            if (stop_go) next_state = CMPC_IDLE;
         end
         default: next_state = CMPC_IDLE;
      endcase
      if (!enabled) next_state = CMPC_IDLE;
   end

   // ladder follows the decision only while live; otherwise rests on upper
   wire next_upper = !(next_state == CMPC_LIVE && cmp_above_i);
   wire [5:0] next_level = next_upper ? th_up : th_dn;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         state          <= CMPC_IDLE;
         core_run_o     <= 1'b0;
         ladder_upper_o <= 1'b1;
         ladder_level_o <= TH_RST;
         irq_o          <= 1'b0;
      end else begin
         state          <= next_state;
         core_run_o     <= next_state != CMPC_IDLE;
         ladder_upper_o <= next_upper;
         ladder_level_o <= next_level;
         irq_o          <= |(events & irq_en);
      end
   end

   // events: hardware set beats a software clear in the same cycle
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_ev
         wire clr = wr_en && wr_addr == OFS_EV_RDY + 12'(4 * g) && wr_strb[0] && !wr_data[0];
         always_ff @(posedge clock_i) begin
            if (!rst_n_i) events[g] <= 1'b0;
            else events[g] <= ev_pulse[g] | (events[g] & ~clr);
         end
      end
   endgenerate

   wire [31:0] wr_cfg_old;
   assign wr_cfg_old = rd_mux(wr_addr);
   wire [31:0] nv = merge(wr_cfg_old, wr_data, wr_strb);

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         links       <= 5'h00;
         irq_en      <= 4'h0;
         result      <= 1'b0;
         block_on    <= EN_OFF;
         pos_pick    <= PIN_RST;
         ref_src     <= REF_RST;
         ext_ref     <= PIN_RST;
         th_up       <= TH_RST;
         th_dn       <= TH_RST;
         speed_power <= SP_RST;
         main_diff   <= 1'b0;
         hyst_on     <= 1'b0;
      end else begin
         if (sample_go) result <= cmp_above_i;
         if (wr_en) begin
            case (wr_addr)
               OFS_LINKS:   links <= nv[4:0];
               OFS_IRQ:     irq_en <= nv[3:0];
               OFS_IRQ_SET: irq_en <= irq_en | wr_m[3:0];
               OFS_IRQ_CLR: irq_en <= irq_en & ~wr_m[3:0];
               OFS_ENABLE:  block_on <= nv[1:0];
               OFS_PSEL:    pos_pick <= nv[2:0];
               OFS_REFSRC:  ref_src <= nv[2:0];
               OFS_EXTREF:  ext_ref <= nv[2:0];
               OFS_TH: begin
                  th_up <= nv[TH_UP_LSB +: TH_W];
                  th_dn <= nv[TH_DN_LSB +: TH_W];
               end
               OFS_MODE: begin
                  speed_power <= nv[1:0];
                  main_diff   <= nv[MODE_MAIN];
               end
               OFS_HYST:    hyst_on <= nv[0];
               default: ;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // analog-side configuration outputs
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         ref_source_o     <= REF_RST;
         ref_pin_o        <= PIN_RST;
         ref_pin_en_o     <= 1'b0;
         positive_input_o <= PIN_RST;
         speed_power_o    <= SP_RST;
         diff_mode_o      <= 1'b0;
         diff_hyst_o      <= 1'b0;
      end else begin
         ref_source_o     <= ref_src;
         ref_pin_o        <= ext_ref;
         ref_pin_en_o     <= ref_src == REF_EXTERNAL_ANALOG_REFERENCE;
         positive_input_o <= pos_pick;
         speed_power_o    <= speed_power;
         diff_mode_o      <= main_diff;
         diff_hyst_o      <= hyst_on & main_diff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read-back
   function automatic logic [31:0] rd_mux(input logic [ADDR_W-1:0] a);
      rd_mux = 32'h00000000;
      case (a)
         OFS_EV_RDY:  rd_mux[0] = events[EV_RDY];
         OFS_EV_DN:   rd_mux[0] = events[EV_DN];
         OFS_EV_UP:   rd_mux[0] = events[EV_UP];
         OFS_EV_CRS:  rd_mux[0] = events[EV_CRS];
         OFS_LINKS:   rd_mux[4:0] = links;
         OFS_IRQ, OFS_IRQ_SET, OFS_IRQ_CLR: rd_mux[3:0] = irq_en;
         OFS_RESULT:  rd_mux[0] = result;
         OFS_ENABLE:  rd_mux[1:0] = block_on;
         OFS_PSEL:    rd_mux[2:0] = pos_pick;
         OFS_REFSRC:  rd_mux[2:0] = ref_src;
         OFS_EXTREF:  rd_mux[2:0] = ext_ref;
         OFS_TH: begin
            rd_mux[TH_UP_LSB +: TH_W] = th_up;
            rd_mux[TH_DN_LSB +: TH_W] = th_dn;
         end
         OFS_MODE: begin
            rd_mux[1:0]       = speed_power;
            rd_mux[MODE_MAIN] = main_diff;
         end
         OFS_HYST:    rd_mux[0] = hyst_on;
         default: ;
      endcase
   endfunction

   assign rd_data = rd_en ? rd_mux(araddr_i) : 32'h00000000;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   ladder_lower_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      live && cmp_above_i && !stop_go && enabled |=> !ladder_upper_o && ladder_level_o == th_dn)
      else $error("ladder not on lower threshold while above");
   ladder_stop_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      stop_go |=> ladder_upper_o && !core_run_o)
      else $error("stop did not halt or restore upper threshold");
   hyst_ignore_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      !main_diff |=> !diff_hyst_o)
      else $error("hysteresis active in single-ended mode");
   start_run_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      start_go && state == CMPC_IDLE |=> core_run_o && state == CMPC_WARM)
      else $error("start task did not start the comparator");
   sample_link_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      rdy_ev && links[LK_RDY_SMP] |=> result == $past(cmp_above_i))
      else $error("ready link did not sample");
   up_stop_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      up_ev && links[LK_UP_STP] |=> state == CMPC_IDLE)
      else $error("up link did not stop");
   mask_set_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      wr_en && wr_addr == OFS_IRQ_SET |=> (irq_en & $past(wr_m[3:0])) == $past(wr_m[3:0]))
      else $error("set alias did not set enable");
   mask_clr_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      wr_en && wr_addr == OFS_IRQ_CLR |=> (irq_en & $past(wr_m[3:0])) == 4'h0)
      else $error("clear alias did not clear enable");
   off_idle_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      block_on != EN_ON |=> !core_run_o)
      else $error("comparator runs while disabled");
   cross_live_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (up_ev || dn_ev) |-> live && crs_ev ##1 events[EV_CRS])
      else $error("crossing event outside live state");
   irq_req_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      |(events & irq_en) |=> irq_o)
      else $error("interrupt not raised for enabled event");
endmodule

// ---- cmpc_pkg.sv ----
// constants, offsets and types shared by the comparator control block
package cmpc_pkg;
   localparam int unsigned ADDR_W = 12;
   localparam logic [11:0] OFS_START   = 12'h000;
   localparam logic [11:0] OFS_STOP    = 12'h004;
   localparam logic [11:0] OFS_SAMPLE  = 12'h008;
   localparam logic [11:0] OFS_EV_RDY  = 12'h100;
   localparam logic [11:0] OFS_EV_DN   = 12'h104;
   localparam logic [11:0] OFS_EV_UP   = 12'h108;
   localparam logic [11:0] OFS_EV_CRS  = 12'h10C;
   localparam logic [11:0] OFS_LINKS   = 12'h200;
   localparam logic [11:0] OFS_IRQ     = 12'h300;
   localparam logic [11:0] OFS_IRQ_SET = 12'h304;
   localparam logic [11:0] OFS_IRQ_CLR = 12'h308;
   localparam logic [11:0] OFS_RESULT  = 12'h400;
   localparam logic [11:0] OFS_ENABLE  = 12'h500;
   localparam logic [11:0] OFS_PSEL    = 12'h504;
   localparam logic [11:0] OFS_REFSRC  = 12'h508;
   localparam logic [11:0] OFS_EXTREF  = 12'h50C;
   localparam logic [11:0] OFS_TH      = 12'h530;
   localparam logic [11:0] OFS_MODE    = 12'h534;
   localparam logic [11:0] OFS_HYST    = 12'h538;
   // field positions
   localparam int unsigned TH_W        = 6;
   localparam int unsigned TH_DN_LSB   = 0;
   localparam int unsigned TH_UP_LSB   = 8;
   localparam int unsigned MODE_MAIN   = 8;
   localparam int unsigned EV_RDY      = 0;
   localparam int unsigned EV_DN       = 1;
   localparam int unsigned EV_UP       = 2;
   localparam int unsigned EV_CRS      = 3;
   localparam int unsigned LK_RDY_SMP  = 0;
   localparam int unsigned LK_RDY_STP  = 1;
   localparam int unsigned LK_DN_STP   = 2;
   localparam int unsigned LK_UP_STP   = 3;
   localparam int unsigned LK_CRS_STP  = 4;
   // values and reset values
   localparam logic [1:0]  EN_OFF      = 2'h0;
   localparam logic [1:0]  EN_ON       = 2'h2;
   localparam logic [2:0]  REF_RST     = 3'h4;
   localparam logic [2:0]  REF_EXTERNAL_ANALOG_REFERENCE    = 3'h5;
   localparam logic [2:0]  PIN_RST     = 3'h0;
   localparam logic [5:0]  TH_RST      = 6'h00;
   localparam logic [1:0]  SP_RST      = 2'h0;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      CMPC_IDLE = 2'b00,
      CMPC_WARM = 2'b01,
      CMPC_LIVE = 2'b10
   } cmpc_run_e;
endpackage

// ---- cmpc_axil.sv ----
// AXI4-Lite slave front end: one write and one read at a time
`timescale 1ns/1ps
module cmpc_axil (
   input  wire logic                        clock_i,
   input  wire logic                        rst_n_i,
   input  wire logic                        awvalid_i,
   output logic                             awready_o,
   input  wire logic [cmpc_pkg::ADDR_W-1:0] awaddr_i,
   input  wire logic                        wvalid_i,
   output logic                             wready_o,
   input  wire logic [31:0]                 wdata_i,
   input  wire logic [3:0]                  wstrb_i,
   output logic                             bvalid_o,
   input  wire logic                        bready_i,
   output logic [1:0]                       bresp_o,
   input  wire logic                        arvalid_i,
   output logic                             arready_o,
   output logic                             rvalid_o,
   input  wire logic                        rready_i,
   output logic [31:0]                      rdata_o,
   output logic [1:0]                       rresp_o,
   output logic                             wr_en_o,
   output logic [cmpc_pkg::ADDR_W-1:0]      wr_addr_o,
   output logic [31:0]                      wr_data_o,
   output logic [3:0]                       wr_strb_o,
   input  wire logic                        wr_ok_i,
   output logic                             rd_en_o,
   input  wire logic [31:0]                 rd_data_i,
   input  wire logic                        rd_ok_i
);
   import cmpc_pkg::*;
   logic aw_have;
   logic w_have;

   // address and data may arrive in either order
   assign wr_en_o = aw_have & w_have & ~bvalid_o;
   assign rd_en_o = arvalid_i & arready_o;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         aw_have   <= 1'b0;
         w_have    <= 1'b0;
         awready_o <= 1'b1;
         wready_o  <= 1'b1;
         bvalid_o  <= 1'b0;
         bresp_o   <= RESP_OKAY;
         wr_addr_o <= '0;
         wr_data_o <= 32'h00000000;
         wr_strb_o <= 4'h0;
      end else begin
         if (awvalid_i && awready_o) begin
            wr_addr_o <= awaddr_i;
            aw_have   <= 1'b1;
            awready_o <= 1'b0;
         end
         if (wvalid_i && wready_o) begin
            wr_data_o <= wdata_i;
            wr_strb_o <= wstrb_i;
            w_have    <= 1'b1;
            wready_o  <= 1'b0;
         end
         if (wr_en_o) begin
            aw_have  <= 1'b0;
            w_have   <= 1'b0;
            bvalid_o <= 1'b1;
            bresp_o  <= wr_ok_i ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_o && bready_i) begin
            bvalid_o  <= 1'b0;
            awready_o <= 1'b1;
            wready_o  <= 1'b1;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         arready_o <= 1'b1;
         rvalid_o  <= 1'b0;
         rdata_o   <= 32'h00000000;
         rresp_o   <= RESP_OKAY;
      end else if (rd_en_o) begin
         arready_o <= 1'b0;
         rvalid_o  <= 1'b1;
         rdata_o   <= rd_data_i;
         rresp_o   <= rd_ok_i ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_o && rready_i) begin
         rvalid_o  <= 1'b0;
         arready_o <= 1'b1;
      end
   end
endmodule

// ---- cmpc_cross.sv ----
// crossing detector on the comparator decision
`timescale 1ns/1ps
module cmpc_cross (
   input  wire logic clock_i,
   input  wire logic rst_n_i,
   input  wire logic live_i,
   input  wire logic above_i,
   output logic      up_o,
   output logic      down_o
);
   import cmpc_pkg::*;
   logic prev_above;

   // tracked always, so the first live cycle compares against a true history
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         prev_above <= 1'b0;
      end else begin
         prev_above <= above_i;
      end
   end

   assign up_o   = live_i & above_i & ~prev_above;
   assign down_o = live_i & ~above_i & prev_above;
endmodule

// ---- comparator_control_tb_top.sv ----
// self-checking bench for the comparator control block
`timescale 1ns/1ps
module comparator_control_tb_top;
   import cmpc_pkg::*;
   logic clock_i = 0, rst_n_i = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata_o, rd;
   logic [3:0]  wstrb = 4'hF;
   logic [1:0]  bresp_o, rresp_o, rr;
   logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, core_run_o, ladder_upper_o, irq_o;
   logic cmp_above = 0, core_ready = 0;
   logic [5:0]  lvl;
   logic [2:0]  rsrc, rpin, ppick;
   logic [1:0]  spd;
   logic rpen, dmode, dhyst;
   int   num_errors = 0, num_checks = 0;
   always #4 clock_i = ~clock_i;
   cmpc_ctrl cmpc_ctrl_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .awvalid_i(awvalid),
      .awready_o(awready_o), .awaddr_i(awaddr), .wvalid_i(wvalid), .wready_o(wready_o),
      .wdata_i(wdata), .wstrb_i(wstrb), .bvalid_o(bvalid_o), .bready_i(bready), .bresp_o(bresp_o),
      .arvalid_i(arvalid), .arready_o(arready_o), .araddr_i(araddr), .rvalid_o(rvalid_o),
      .rready_i(rready), .rdata_o(rdata_o), .rresp_o(rresp_o), .cmp_above_i(cmp_above),
      .core_ready_i(core_ready), .core_run_o(core_run_o), .ladder_upper_o(ladder_upper_o),
      .ladder_level_o(lvl), .ref_source_o(rsrc), .ref_pin_o(rpin), .ref_pin_en_o(rpen),
      .positive_input_o(ppick), .speed_power_o(spd), .diff_mode_o(dmode), .diff_hyst_o(dhyst),
      .irq_o(irq_o));
   ////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         num_errors++;
      end
   endtask
   task automatic hang(input logic ok);
      if (!ok) begin
         $display("[ERR] bus answer expected 1 seen 0");
         num_errors++;
         stop_test();
      end
   endtask
   // bus cycles: payload held until each channel's own ready is sampled high
   // bready and rready stay high between calls, so no time step lowers and raises them
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] exp_resp);
      int n = 0;
      logic done = 0;
      awvalid <= 1;
      wvalid <= 1;
      awaddr <= a;
      wdata <= d;
      bready <= 1;
      while (!done && n < 200) begin
         @(posedge clock_i);
         if (awvalid && awready_o) awvalid <= 0;
         if (wvalid && wready_o) wvalid <= 0;
         if (bvalid_o === 1'b1) begin
            done = 1;
            rr = bresp_o;
         end
         n++;
      end
      hang(done);
      chk("write response", {30'h0, exp_resp}, {30'h0, rr});
   endtask
   task automatic rd_reg(input logic [11:0] a, input logic [1:0] exp_resp);
      int n = 0;
      logic done = 0;
      arvalid <= 1;
      araddr <= a;
      rready <= 1;
      while (!done && n < 200) begin
         @(posedge clock_i);
         if (arvalid && arready_o) arvalid <= 0;
         if (rvalid_o === 1'b1) begin
            done = 1;
            rd = rdata_o;
            rr = rresp_o;
         end
         n++;
      end
      hang(done);
      chk("read response", {30'h0, exp_resp}, {30'h0, rr});
   endtask
   task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
      rd_reg(a, RESP_OKAY);
      chk(what, exp, rd);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_values();
      rd_chk("reference_source", OFS_REFSRC, 32'h0000_0004);
      rd_chk("block_on", OFS_ENABLE, 32'h0000_0000);
      rd_reg(12'h600, RESP_SLVERR);
      chk("unmapped data", 32'h0000_0000, rd);
      $display("test reset values done");
   endtask
   task automatic t_irq_aliases();
      wr(OFS_IRQ_SET, 32'h0000_0005, RESP_OKAY);
      rd_chk("irq_mask after set", OFS_IRQ, 32'h0000_0005);
      wr(OFS_IRQ_CLR, 32'h0000_0004, RESP_OKAY);
      rd_chk("set alias read", OFS_IRQ_SET, 32'h0000_0001);
      rd_chk("clear alias read", OFS_IRQ_CLR, 32'h0000_0001);
      $display("test irq aliases done");
   endtask
   // set-up before enabling; differential first, so hysteresis is seen to follow the mode
   task automatic t_config();
      wr(OFS_PSEL, 32'h0000_0003, RESP_OKAY);
      wr(OFS_REFSRC, 32'h0000_0005, RESP_OKAY);
      wr(OFS_EXTREF, 32'h0000_0006, RESP_OKAY);
      wr(OFS_HYST, 32'h0000_0001, RESP_OKAY);
      wr(OFS_MODE, 32'h0000_0102, RESP_OKAY);
      @(posedge clock_i);
      chk("positive input", 32'h3, {29'h0, ppick});
      chk("reference source out", 32'h5, {29'h0, rsrc});
      chk("reference pin", 32'h6, {29'h0, rpin});
      chk("reference pin enable", 32'h1, {31'h0, rpen});
      chk("speed power", 32'h2, {30'h0, spd});
      chk("differential mode", 32'h1, {31'h0, dmode});
      chk("differential hysteresis", 32'h1, {31'h0, dhyst});
      wr(OFS_MODE, 32'h0000_0002, RESP_OKAY);
      @(posedge clock_i);
      chk("single-ended mode", 32'h0, {31'h0, dmode});
      chk("hysteresis ignored", 32'h0, {31'h0, dhyst});
      $display("test configuration done");
   endtask
   // warm-up length comes from core ready, so the bench decides it
   task automatic t_start_sample();
      wr(OFS_TH, 32'h0000_2010, RESP_OKAY);
      wr(OFS_LINKS, 32'h0000_0001, RESP_OKAY);
      wr(OFS_ENABLE, {30'h0, EN_ON}, RESP_OKAY);
      cmp_above <= 1;
      wr(OFS_START, 32'h0000_0001, RESP_OKAY);
      chk("run after start", 32'h1, {31'h0, core_run_o});
      core_ready <= 1;
      repeat (4) @(posedge clock_i);
      chk("ladder on lower", 32'h0, {31'h0, ladder_upper_o});
      chk("ladder level lower", 32'h10, {26'h0, lvl});
      chk("irq with ready", 32'h1, {31'h0, irq_o});
      rd_chk("ready event", OFS_EV_RDY, 32'h0000_0001);
      rd_chk("sampled result", OFS_RESULT, 32'h0000_0001);
      wr(OFS_EV_RDY, 32'h0000_0000, RESP_OKAY);
      rd_chk("ready event cleared", OFS_EV_RDY, 32'h0000_0000);
      @(posedge clock_i);
      chk("irq after clear", 32'h0, {31'h0, irq_o});
      $display("test start and sample done");
   endtask
   task automatic t_crossing_to_halt_link();
      wr(OFS_LINKS, 32'h0000_0010, RESP_OKAY);
      cmp_above <= 0;
      repeat (4) @(posedge clock_i);
      rd_chk("down event", OFS_EV_DN, 32'h0000_0001);
      rd_chk("cross event", OFS_EV_CRS, 32'h0000_0001);
      chk("stopped by link", 32'h0, {31'h0, core_run_o});
      chk("ladder back upper", 32'h1, {31'h0, ladder_upper_o});
      chk("ladder level upper", 32'h20, {26'h0, lvl});
      cmp_above <= 1;
      repeat (4) @(posedge clock_i);
      rd_chk("no up while stopped", OFS_EV_UP, 32'h0000_0000);
      // below now, so the sample must overwrite the earlier 1
      cmp_above <= 0;
      wr(OFS_SAMPLE, 32'h0000_0001, RESP_OKAY);
      rd_chk("sample task result", OFS_RESULT, 32'h0000_0000);
      wr(OFS_START, 32'h0000_0001, RESP_OKAY);
      chk("run after restart", 32'h1, {31'h0, core_run_o});
      wr(OFS_STOP, 32'h0000_0001, RESP_OKAY);
      chk("stopped by stop task", 32'h0, {31'h0, core_run_o});
      $display("test crossing stop done");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge clock_i);
      rst_n_i <= 1;
      @(posedge clock_i);
      t_reset_values();
      t_irq_aliases();
      t_config();
      t_start_sample();
      t_crossing_to_halt_link();
      stop_test();
   end
endmodule
